// file: src/ffca_pkg.sv
/*
 * Shared constants of the fragment fog and coverage stage: register
 * offsets, field positions, reset values and fixed-point figures.
 * Assumes a plain register port with word offsets and one core clock.
 */
package ffca_pkg;
    // register offsets
    localparam logic [3:0] FFCA_OFS_FOG_CONTROL = 4'h0;
    localparam logic [3:0] FFCA_OFS_FOG_COLOUR = 4'h1;
    localparam logic [3:0] FFCA_OFS_FOG_START = 4'h2;
    localparam logic [3:0] FFCA_OFS_FOG_X_GRAD = 4'h3;
    localparam logic [3:0] FFCA_OFS_FOG_DOM_GRAD = 4'h4;
    localparam logic [3:0] FFCA_OFS_COV_CONTROL = 4'h5;
    localparam logic [3:0] FFCA_OFS_FOG_INDEX = 4'h6;
    // control fields, same layout in both control registers
    localparam int FFCA_BIT_ENABLE = 0;
    localparam int FFCA_BIT_FORMAT = 1;
    localparam logic FFCA_FMT_RGBA = 1'b0;
    localparam logic FFCA_FMT_CI = 1'b1;
    // reset values
    localparam logic [1:0] FFCA_RST_CONTROL = 2'h0;
    localparam logic [31:0] FFCA_RST_WORD = 32'h0000_0000;
    // 10.22 fixed point
    localparam int FFCA_FRAC_BITS = 22;
    localparam logic [31:0] FFCA_FOG_ONE = 32'h0040_0000;
    // clamped fog weight keeps 8 fraction bits, 256 is 1.0
    localparam int FFCA_WEIGHT_SHIFT = 14;
    localparam logic [8:0] FFCA_WEIGHT_ONE = 9'h100;
    // coverage: 16 means full coverage
    localparam logic [4:0] FFCA_COV_FULL = 5'h10;
    localparam int FFCA_FIFO_DEPTH = 4;
endpackage

// file: src/ffca_stage.sv
/*
 * Fragment fog and coverage stage, plus its output FIFO.
 * Fragments arrive from the colour/texture units on the same clock with
 * valid/ready; results go to the alpha test side with valid/ready.
 * Software loads controls through a plain strobed register port.
 */
// Local design decisions: the register addresses and the strobed register port.
// Operation
// - fog blends fragment colour with fog colour
// - fog index interpolated incrementally per fragment
// - fog runs in parallel, full throughput
// - step by x gradient, edge gradient; lines skip x
// - fog index held as 32 bits
// - fog registers are signed 10.22
// - accumulator spans about -512 to +511
// - fog index clamped to zero..one before blend
// - colour format selects fog formula
// - rgba: f*ci + (1-f)*cf, alpha kept
// - ci: ii + (1-f)*if
// - fog needs control enable and qualifier bit
// - fog colour register is the fog operand
// - colour format selects coverage behaviour
// - rgba: alpha times coverage, rgb kept
// - ci: coverage into low four bits
// - coverage needs control enable and qualifier bit
`timescale 1ns/1ps

module ffca_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module ffca_stage #(
    parameter int FIFO_DEPTH = ffca_pkg::FFCA_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // incoming fragment
    input wire logic frag_in_valid,
    output logic frag_in_ready,
    input wire logic [31:0] frag_in_colour,
    input wire logic [4:0] frag_in_coverage,
    input wire logic frag_in_prim_start,
    input wire logic frag_in_span_start,
    input wire logic frag_in_is_line,
    input wire logic fog_qualifier_bit,
    input wire logic coverage_qualifier_bit,
    // outgoing fragment
    output logic frag_out_valid,
    input wire logic frag_out_ready,
    output logic [31:0] frag_out_colour
);
    logic [1:0] fog_control;
    logic [31:0] fog_colour_value;
    logic [31:0] fog_start_value;
    logic [31:0] fog_x_gradient;
    logic [31:0] fog_dominant_edge_gradient;
    logic [1:0] coverage_apply_control;
    logic [31:0] fog_acc;
    logic [31:0] fog_edge;
    logic [31:0] next_fog;
    logic [8:0] fog_weight;
    logic [8:0] fog_inv;
    logic fog_on;
    logic coverage_apply_on;
    logic [31:0] fogged;
    logic [31:0] covered;
    logic take;
    logic s1_valid;
    logic [31:0] s1_colour;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [31:0] fifo_out_data;

    // registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fog_control <= ffca_pkg::FFCA_RST_CONTROL;
            fog_colour_value <= ffca_pkg::FFCA_RST_WORD;
            fog_start_value <= ffca_pkg::FFCA_RST_WORD;
            fog_x_gradient <= ffca_pkg::FFCA_RST_WORD;
            fog_dominant_edge_gradient <= ffca_pkg::FFCA_RST_WORD;
            coverage_apply_control <= ffca_pkg::FFCA_RST_CONTROL;
        end else if (reg_write) begin
            unique case (reg_addr)
                ffca_pkg::FFCA_OFS_FOG_CONTROL: fog_control <= reg_wdata[1:0];
                ffca_pkg::FFCA_OFS_FOG_COLOUR: fog_colour_value <= reg_wdata;
                ffca_pkg::FFCA_OFS_FOG_START: fog_start_value <= reg_wdata;
                ffca_pkg::FFCA_OFS_FOG_X_GRAD: fog_x_gradient <= reg_wdata;
                ffca_pkg::FFCA_OFS_FOG_DOM_GRAD: fog_dominant_edge_gradient <= reg_wdata;
                ffca_pkg::FFCA_OFS_COV_CONTROL: coverage_apply_control <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= ffca_pkg::FFCA_RST_WORD;
        end else if (!reg_read) begin
            reg_rdata <= ffca_pkg::FFCA_RST_WORD;
        end else begin
            unique case (reg_addr)
                ffca_pkg::FFCA_OFS_FOG_CONTROL: reg_rdata <= {30'h0, fog_control};
                ffca_pkg::FFCA_OFS_FOG_COLOUR: reg_rdata <= fog_colour_value;
                ffca_pkg::FFCA_OFS_FOG_START: reg_rdata <= fog_start_value;
                ffca_pkg::FFCA_OFS_FOG_X_GRAD: reg_rdata <= fog_x_gradient;
                ffca_pkg::FFCA_OFS_FOG_DOM_GRAD: reg_rdata <= fog_dominant_edge_gradient;
                ffca_pkg::FFCA_OFS_COV_CONTROL: reg_rdata <= {30'h0, coverage_apply_control};
                ffca_pkg::FFCA_OFS_FOG_INDEX: reg_rdata <= fog_acc;
                default: reg_rdata <= ffca_pkg::FFCA_RST_WORD;
            endcase
        end
    end

    assign take = frag_in_valid && frag_in_ready;
    // one fragment per cycle; only back-pressure from downstream stalls
    assign frag_in_ready = !s1_valid || fifo_in_ready;

    // index for this fragment; lines step the edge gradient only
    always_comb begin
        if (frag_in_prim_start) begin
            next_fog = fog_start_value;
        end else if (frag_in_span_start || frag_in_is_line) begin
            next_fog = fog_edge + fog_dominant_edge_gradient;
        end else begin
            next_fog = fog_acc + fog_x_gradient;
        end
    end

    // plain 32-bit wrap: out-of-range primitives give wrong fog
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fog_acc <= ffca_pkg::FFCA_RST_WORD;
            fog_edge <= ffca_pkg::FFCA_RST_WORD;
        end else if (take) begin
            fog_acc <= next_fog;
            if (frag_in_prim_start || frag_in_span_start || frag_in_is_line) begin
                fog_edge <= next_fog;
            end
        end
    end

    // clamp to 0.0..1.0 then keep 8 fraction bits
    always_comb begin
        if (next_fog[31]) begin
            fog_weight = 9'h000;
        end else if (next_fog >= ffca_pkg::FFCA_FOG_ONE) begin
            fog_weight = ffca_pkg::FFCA_WEIGHT_ONE;
        end else begin
            fog_weight = next_fog[ffca_pkg::FFCA_FRAC_BITS:ffca_pkg::FFCA_WEIGHT_SHIFT];
        end
        fog_inv = ffca_pkg::FFCA_WEIGHT_ONE - fog_weight;
    end

    assign fog_on = fog_control[ffca_pkg::FFCA_BIT_ENABLE] && fog_qualifier_bit;
    assign coverage_apply_on = coverage_apply_control[ffca_pkg::FFCA_BIT_ENABLE]
        && coverage_qualifier_bit;

    function automatic logic [7:0] ffca_mix(input logic [7:0] c_in, input logic [7:0] c_fog,
                                            input logic [8:0] w, input logic [8:0] wi);
        logic [17:0] sum;
        // widen before multiplying: a product inside a concatenation keeps only 9 bits
        sum = 18'(w) * 18'(c_in) + 18'(wi) * 18'(c_fog);
        return sum[15:8];
    endfunction

    // fog blend
    always_comb begin
        logic [16:0] ci_add;
        ci_add = 17'(fog_inv) * 17'(fog_colour_value[7:0]);
        fogged = frag_in_colour;
        if (fog_on) begin
            if (fog_control[ffca_pkg::FFCA_BIT_FORMAT] == ffca_pkg::FFCA_FMT_RGBA) begin
                fogged[7:0] = ffca_mix(frag_in_colour[7:0], fog_colour_value[7:0],
                    fog_weight, fog_inv);
                fogged[15:8] = ffca_mix(frag_in_colour[15:8], fog_colour_value[15:8],
                    fog_weight, fog_inv);
                fogged[23:16] = ffca_mix(frag_in_colour[23:16], fog_colour_value[23:16],
                    fog_weight, fog_inv);
            end else begin
                fogged[7:0] = frag_in_colour[7:0] + ci_add[15:8];
            end
        end
    end

    // coverage after fog; format picks alpha or index bits
    always_comb begin
        logic [12:0] prod;
        prod = fogged[31:24] * frag_in_coverage;
        covered = fogged;
        if (coverage_apply_on) begin
            if (coverage_apply_control[ffca_pkg::FFCA_BIT_FORMAT] == ffca_pkg::FFCA_FMT_RGBA) begin
                covered[31:24] = prod[11:4];
                if (frag_in_coverage >= ffca_pkg::FFCA_COV_FULL) begin
                    covered[31:24] = fogged[31:24];
                end
            end else begin
                // saturate so full coverage lands on the brightest of 16
                covered[3:0] = frag_in_coverage[4] ? 4'hf : frag_in_coverage[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s1_valid <= 1'b0;
            s1_colour <= ffca_pkg::FFCA_RST_WORD;
        end else if (frag_in_ready) begin
            s1_valid <= frag_in_valid;
            s1_colour <= covered;
        end
    end

    ffca_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .in_valid(s1_valid),
        .in_ready(fifo_in_ready),
        .in_data(s1_colour),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // output register keeps frag_out_valid and frag_out_colour on flip-flops
    assign fifo_pop = !frag_out_valid || frag_out_ready;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            frag_out_valid <= 1'b0;
            frag_out_colour <= ffca_pkg::FFCA_RST_WORD;
        end else if (fifo_pop) begin
            frag_out_valid <= fifo_out_valid;
            frag_out_colour <= fifo_out_data;
        end
    end
endmodule

// file: verification/ffca_stage_asserts.sv
/*
 * Port checker for the fog and coverage stage, bound into ffca_stage.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module ffca_stage_asserts #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic frag_in_valid,
    input wire logic frag_in_ready,
    input wire logic frag_out_valid,
    input wire logic frag_out_ready,
    input wire logic [31:0] frag_out_colour
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    logic [31:0] colour_shadow;
    logic [7:0] inflight;
    // writes land a cycle later, so the shadow matches what a read sees
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            colour_shadow <= 32'h0;
        else if (reg_write && reg_addr == ffca_pkg::FFCA_OFS_FOG_COLOUR)
            colour_shadow <= reg_wdata;
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            inflight <= 8'h0;
        else
            inflight <= inflight + 8'(frag_in_valid && frag_in_ready)
                - 8'(frag_out_valid && frag_out_ready);
    end
    AST_RDATA_IDLE:
    assert property (!reg_read |=> reg_rdata == 32'h0) else $error("read data not idle");
    AST_COLOUR_READ:
    assert property (reg_read && reg_addr == ffca_pkg::FFCA_OFS_FOG_COLOUR
        |=> reg_rdata == $past(colour_shadow)) else $error("fog colour readback");
    AST_CTRL_HIGH_ZERO:
    assert property (reg_read && (reg_addr == 4'h0 || reg_addr == 4'h5)
        |=> reg_rdata[31:2] == 30'h0) else $error("control upper bits set");
    AST_UNMAPPED_ZERO:
    assert property (reg_read && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_OUT_HOLD:
    assert property (frag_out_valid && !frag_out_ready
        |=> frag_out_valid && $stable(frag_out_colour)) else $error("output dropped in stall");
    AST_FULL_MEANS_OUT:
    assert property (!frag_in_ready |-> frag_out_valid) else $error("refused while output empty");
    AST_NO_PHANTOM:
    assert property (frag_out_valid |-> inflight != 8'h0) else $error("output without input");
    AST_INFLIGHT_MAX:
    assert property (inflight <= 8'(FIFO_DEPTH + 2)) else $error("too many fragments held");
endmodule

bind ffca_stage ffca_stage_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_asserts (.*);

// file: verification/ffca_frag_src.sv
/*
 * Upstream fragment source: one fragment at a time, held until taken.
 * Assumes calls from the bench just after a rising edge.
 */
`timescale 1ns/1ps
module ffca_frag_src (
    input wire logic ref_clk,
    input wire logic frag_in_ready,
    output logic frag_in_valid,
    output logic [31:0] frag_in_colour,
    output logic [4:0] frag_in_coverage,
    output logic frag_in_prim_start,
    output logic frag_in_span_start,
    output logic frag_in_is_line,
    output logic fog_qualifier_bit,
    output logic coverage_qualifier_bit
);
    initial begin
        frag_in_valid = 1'b0;
        frag_in_colour = 32'h0;
        frag_in_coverage = 5'h0;
        {frag_in_prim_start, frag_in_span_start, frag_in_is_line} = 3'h0;
        {fog_qualifier_bit, coverage_qualifier_bit} = 2'h0;
    end
    // stale colour is inverted so a released word never looks current
    task automatic idle();
        frag_in_valid <= 1'b0;
        frag_in_colour <= ~frag_in_colour;
    endtask
    task automatic send(input logic [31:0] c, input logic [4:0] cv, input logic [4:0] f,
            input int gap);
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge ref_clk);
        end
        frag_in_colour <= c;
        frag_in_coverage <= cv;
        {frag_in_prim_start, frag_in_span_start, frag_in_is_line} <= f[4:2];
        {fog_qualifier_bit, coverage_qualifier_bit} <= f[1:0];
        frag_in_valid <= 1'b1;
        @(posedge ref_clk);
        while (frag_in_ready !== 1'b1) @(posedge ref_clk);
    endtask
endmodule

// file: verification/tb_fragment_fog_and_coverage_apply.sv
/*
 * Bench for the fog and coverage stage: registers, random streams, stalls.
 * Assumes the source model and the bound checker.
 */
`timescale 1ns/1ps
module tb_fragment_fog_and_coverage_apply;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic frag_out_ready = 1'b0;
    logic stall = 1'b1;
    logic [31:0] reg_rdata, frag_in_colour, frag_out_colour, c, e;
    logic [4:0] frag_in_coverage, cv, fl;
    logic frag_in_valid, frag_in_ready, frag_in_prim_start, frag_in_span_start, frag_in_is_line;
    logic fog_qualifier_bit, coverage_qualifier_bit, frag_out_valid;
    logic [1:0] fctl = 2'h0, cctl = 2'h0;
    logic [31:0] fcol = 32'h0, fst = 32'h0, fx = 32'h0, fdm = 32'h0, idx = 32'h0, edg = 32'h0;
    logic [31:0] q[$];
    int seed = 91867;
    int error_cnt = 0;
    int n_compared = 0;
    ffca_stage uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .frag_in_valid(frag_in_valid), .frag_in_ready(frag_in_ready),
        .frag_in_colour(frag_in_colour), .frag_in_coverage(frag_in_coverage),
        .frag_in_prim_start(frag_in_prim_start), .frag_in_span_start(frag_in_span_start),
        .frag_in_is_line(frag_in_is_line), .fog_qualifier_bit(fog_qualifier_bit),
        .coverage_qualifier_bit(coverage_qualifier_bit), .frag_out_valid(frag_out_valid),
        .frag_out_ready(frag_out_ready), .frag_out_colour(frag_out_colour));
    ffca_frag_src src (.*);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("TB: errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        case (a)
            4'h0: fctl = d[1:0];
            4'h1: fcol = d;
            4'h2: fst = d;
            4'h3: fx = d;
            4'h4: fdm = d;
            4'h5: cctl = d[1:0];
            default: ;
        endcase
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
        @(posedge ref_clk);
    endtask
    function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
            input logic [8:0] w);
        logic [16:0] s;
        s = w * a + (9'h100 - w) * b;
        return s[15:8];
    endfunction
    function automatic logic [31:0] exp_out(input logic [31:0] ci, input logic [4:0] cov,
            input logic [4:0] f);
        logic [8:0] w;
        logic [31:0] r;
        logic [12:0] t;
        if (f[4]) begin
            edg = fst;
            idx = fst;
        end else if (f[3] || f[2]) begin
            edg = edg + fdm;
            idx = edg;
        end else
            idx = idx + fx;
        w = idx[31] ? 9'h000 : (idx >= ffca_pkg::FFCA_FOG_ONE ? ffca_pkg::FFCA_WEIGHT_ONE
            : {1'b0, idx[21:14]});
        r = ci;
        if (fctl == 2'h3 && f[1]) r[7:0] = ci[7:0] + mix(8'h00, fcol[7:0], w);
        if (fctl == 2'h1 && f[1])
            for (int k = 0; k < 3; k++) r[8*k+:8] = mix(ci[8*k+:8], fcol[8*k+:8], w);
        t = r[31:24] * cov;
        if (cctl == 2'h3 && f[0]) r[3:0] = cov > 5'h0f ? 4'hf : cov[3:0];
        if (cctl == 2'h1 && f[0] && cov < 5'h10) r[31:24] = t[11:4];
        return r;
    endfunction
    always @(posedge ref_clk) begin
        frag_out_ready <= !stall && $random(seed) % 2 != 0;
        if (reset_n && frag_out_valid === 1'b1 && frag_out_ready === 1'b1) begin
            e = q.size() != 0 ? q.pop_front() : 32'hx;
            chk(frag_out_colour, e);
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        stall <= 1'b0;
        @(posedge ref_clk);
        for (int a = 0; a < 8; a++) rd(a[3:0], 32'h0);
        wr(4'h1, 32'h5a3c_96e1);
        rd(4'h1, 32'h5a3c_96e1);
        wr(4'h5, 32'hffff_ffff);
        rd(4'h5, 32'h0000_0003);
        wr(4'h7, 32'hffff_ffff);
        rd(4'h7, 32'h0);
        for (int m = 0; m < 16; m++) begin
            wr(4'h0, 32'(m));
            wr(4'h5, 32'(m >> 2));
            wr(4'h1, $random(seed));
            // start spans below zero to above one so both clamps are hit
            wr(4'h2, {$random(seed)} % 8388608 - 1048576);
            wr(4'h3, $random(seed) % 262144);
            wr(4'h4, $random(seed) % 262144);
            fork
                begin
                    for (int j = 0; j < 12; j++) begin
                        c = $random(seed);
                        cv = 5'({$random(seed)} % 17);
                        fl = 5'($random(seed));
                        fl[4] = (j == 0);
                        q.push_back(exp_out(c, cv, fl));
                        src.send(c, cv, fl, {$random(seed)} % 2);
                    end
                    src.idle();
                end
                begin
                    stall <= 1'b1;
                    repeat (20) @(posedge ref_clk);
                    @(negedge ref_clk);
                    chk({31'h0, frag_in_ready}, 32'h0);
                    @(posedge ref_clk);
                    stall <= 1'b0;
                end
            join
            for (int k = 0; k < 300 && q.size() != 0; k++) @(posedge ref_clk);
            @(negedge ref_clk);
            chk(32'(q.size()) + frag_out_valid, 32'h0);
            @(posedge ref_clk);
            rd(4'h6, idx);
        end
        // mid-run reset: both control registers, fog colour and fog index must return to zero
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({31'h0, frag_out_valid}, 32'h0);
        @(posedge ref_clk);
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        rd(4'h5, 32'h0);
        rd(4'h6, 32'h0);
        test_done();
    end
    initial begin
        #2000000;
        error_cnt++;
        $display("ERROR %0t: timeout", $time);
        test_done();
    end
endmodule
